// ==== verilog/lra_pkg.sv ====
// lane register access port: shared constants and carrier types
// assumes one clock (aclk) for the bus, the lane ports and the sidebands
`default_nettype none

package lra_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int          NL       = 4;   // lanes in the quad
	localparam int          LW       = 2;   // lane index width
	localparam int          OFS_W    = 9;   // lane access offset width
	localparam int          SPACE_B  = 8;   // offset bit that picks the space
	localparam int          DAT_W    = 8;   // lane access data width
	localparam int          CFG_W    = 4;   // per-lane setting width
	localparam int          PWR_W    = 2;   // power state width
	localparam int          POS_W    = 4;   // slip position width
	localparam logic        SEL_MPCS = 1'b1;
	localparam logic        SEL_PMA  = 1'b0;

	// ----------------------------------------------------------------
	// register map (byte addresses) and layout
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  ADDR_CTRL  = 8'h00; // lane enables
	localparam logic [7:0]  ADDR_PWR   = 8'h04; // power state per lane
	localparam logic [7:0]  ADDR_DEEMP = 8'h08; // de-emphasis setting
	localparam logic [7:0]  ADDR_OOB   = 8'h0C; // oob detector setting
	localparam logic [7:0]  ADDR_STAT  = 8'h10; // lane status, read only
	localparam logic [7:0]  ADDR_SLIP  = 8'h14; // slip positions, read only
	localparam int          STAT_RST_B = 8;     // lane out of reset
	localparam int          STAT_OOB_B = 16;    // oob control level
	localparam int          STAT_DEE_B = 24;    // de-emphasis control level
	localparam logic [31:0] MASK_CTRL  = 32'h0000000F;
	localparam logic [31:0] MASK_PWR   = 32'h000000FF;
	localparam logic [31:0] MASK_CFG   = 32'h0000FFFF;
	localparam logic [31:0] RST_REG    = 32'h00000000;

	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	localparam logic [1:0]  PWR_ACTIVE  = 2'b00;
	localparam logic [3:0]  DET_NORMAL  = 4'h0;
	localparam logic [3:0]  DEEMP_NONE  = 4'h0;
	localparam logic [3:0]  POS_ZERO    = 4'h0;
	localparam logic [3:0]  POS_LAST    = 4'h9; // ten-bit parallel word

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic               request;
		logic               wr_rdn;
		logic [OFS_W-1:0]   offset;
		logic [DAT_W-1:0]   wdata;
	} lra_lane_req_t;

	typedef struct packed {
		logic               ready;
		logic               rdata_valid;
		logic [DAT_W-1:0]   rdata;
	} lra_lane_rsp_t;

	typedef struct packed {
		logic [NL-1:0]              rst_m, rst_s;
		logic [NL-1:0]              oob_m, oob_s;
		logic [NL-1:0]              dee_m, dee_s;
		logic [NL-1:0]              skp_m, skp_s, skp_d;
		logic [NL-1:0][POS_W-1:0]   slip;
		lra_lane_rsp_t [NL-1:0]     rsp;
		logic [NL-1:0][CFG_W-1:0]   dee_out, det_out;
		logic [NL-1:0][PWR_W-1:0]   pwrst;
		logic [NL-1:0]              rdy;
		logic [31:0]                ctrl, pwr, dee, oob;
		logic                       awv, wv;
		logic [ADDR_W-1:0]          awaddr;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       awready, wready, bvalid;
		logic [1:0]                 bresp;
		logic                       arready, rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
	} lra_state_t;

endpackage

`default_nettype wire

// ==== verilog/lra_lane_port.sv ====
// lane register access port with sideband controls and a register bank
// assumes fabric logic on aclk for lane ports; sideband pins are async
//
// Summary of operation
// [RULE1] every lane has its own access port with reset and handshake.
// [RULE2] a low lane reset holds that lane's access port in reset.
// [RULE3] the master drives the direction high to write, low to read.
// [RULE4] the offset is 9 bits and its top bit picks PCS or PMA space.
// [RULE5] a request is accepted on ready; read data comes with valid.
// [RULE6] while de-emphasis control is high the setting is applied.
// [RULE7] each rising edge of bit skip moves the word by one UI.
// [RULE8] each lane reports its power state on a two-bit output.
// [RULE9] the oob control sets the activity detector for oob signals.
// [RULE10] ready releases the external PCS and permits transmission.
`default_nettype none

module lra_lane_port #(
	parameter int DEPTH_W = 4  // stored bytes per space = 2**DEPTH_W
) (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [lra_pkg::ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [31:0]                       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [lra_pkg::ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [31:0]                            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic [lra_pkg::NL-1:0]            lane_resetn,
	input  wire lra_pkg::lra_lane_req_t [lra_pkg::NL-1:0] lane_req,
	output lra_pkg::lra_lane_rsp_t [lra_pkg::NL-1:0]      lane_rsp,
	input  wire logic [lra_pkg::NL-1:0]            oob_ctl,
	input  wire logic [lra_pkg::NL-1:0]            deemp_ctl,
	input  wire logic [lra_pkg::NL-1:0]            skip_bit,
	output logic [lra_pkg::NL-1:0][lra_pkg::CFG_W-1:0] tx_deemp,
	output logic [lra_pkg::NL-1:0][lra_pkg::CFG_W-1:0] rx_det_cfg,
	output logic [lra_pkg::NL-1:0][lra_pkg::PWR_W-1:0] pwr_state,
	output logic [lra_pkg::NL-1:0]                phy_ready,
	output logic [lra_pkg::NL-1:0][lra_pkg::POS_W-1:0] slip_pos
);
	import lra_pkg::*;

	localparam int IDX_W = LW + 1 + DEPTH_W;

	lra_state_t s_r;
	lra_state_t s_nxt;

	// per-lane byte store, both spaces of every lane
	logic [DAT_W-1:0] space_mem [2**IDX_W];
	logic [NL-1:0]    mem_we;
	logic [NL-1:0][IDX_W-1:0] mem_idx;

	// ----------------------------------------------------------------
	// register map and timing
	// ----------------------------------------------------------------
	// 0x00 lane enables, one bit per lane
	// 0x04 power state, two bits per lane; 00 is the active state
	// 0x08 de-emphasis setting, four bits per lane
	// 0x0C oob detector setting, four bits per lane
	// 0x10 status: ready 3:0, out of reset 11:8, oob 19:16, deemp 27:24
	// 0x14 slip positions, four bits per lane
	// 0x10 and 0x14 take writes with okay and keep their contents
	// any other word answers slave error and changes nothing
	// address bits 1:0 are ignored; reads return a whole word, writes follow the byte strobes
	// bits above a register's mask always read as zero
	//
	// reset: bus ready lines rise at the first edge after release
	// bus write: bvalid two edges after the later of address and data
	// bus write: address and data ready stay low until bvalid clears
	// bus read: rvalid the edge after the address is taken
	// lane port: ready, and for a read the data, one edge after taking
	// lane port: a request still high under ready is not taken again
	// pins: three edges from a pin to its output, the slip included
	// lane reset: three edges from release to the first take
	//
	// limitations
	// offset bits between DEPTH_W and the space bit alias each other
	// unwritten bytes read unknown, so software writes before reading
	// every lane shares the bus clock; no crossing inside the block

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte-lane merge for the bus writes
	// strobes pick bytes; the mask then clears unused bits
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	// offset bits between DEPTH_W and the space bit alias
	// index is lane, then space, then the low offset bits
	function automatic logic [IDX_W-1:0] slot(input int lane,
		input logic [OFS_W-1:0] ofs);
		return {LW'(lane), ofs[SPACE_B], ofs[DEPTH_W-1:0]};
	endfunction

	// register read decode; unmapped answers error with zero data
	function automatic logic [33:0] rd_word(input lra_state_t st,
		input logic [ADDR_W-1:0] a);
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'h00000000;
		r = RESP_OKAY;
		case ({a[ADDR_W-1:2], 2'b00})
			ADDR_CTRL:  d = st.ctrl;
			ADDR_PWR:   d = st.pwr;
			ADDR_DEEMP: d = st.dee;
			ADDR_OOB:   d = st.oob;
			ADDR_STAT: begin
				// synchronised copies, not the raw pins
				d[0 +: NL]          = st.rdy;
				d[STAT_RST_B +: NL] = st.rst_s;
				d[STAT_OOB_B +: NL] = st.oob_s;
				d[STAT_DEE_B +: NL] = st.dee_s;
			end
			ADDR_SLIP:  d[NL*POS_W-1:0] = st.slip;
			default:    r = RESP_SLVERR;
		endcase
		return {r, d};
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [33:0]      rw;
		logic             take;
		logic [NL-1:0]    fall;
		rw     = 34'h000000000;
		take   = 1'b0;
		fall   = '0;
		s_nxt  = s_r;
		mem_we = '0;
		mem_idx = '0;

		// two flops on every pin before use
		s_nxt.rst_m = lane_resetn;
		s_nxt.rst_s = s_r.rst_m;
		s_nxt.oob_m = oob_ctl;
		s_nxt.oob_s = s_r.oob_m;
		s_nxt.dee_m = deemp_ctl;
		s_nxt.dee_s = s_r.dee_m;
		s_nxt.skp_m = skip_bit;
		s_nxt.skp_s = s_r.skp_m;
		// third skip flop only feeds the edge detector
		s_nxt.skp_d = s_r.skp_s;

		for (int i = 0; i < NL; i++) begin
			// one access port per lane, own reset and handshake
			mem_idx[i] = slot(i, lane_req[i].offset); // RULE1 RULE4
			if (!s_r.rst_s[i]) begin
				s_nxt.rsp[i] = '0; // RULE2
			end else begin
				// accept one request, ready low between takes
				take = lane_req[i].request && !s_r.rsp[i].ready;
				s_nxt.rsp[i].ready = take; // RULE5
				// a write lands in the store at the taking edge
				mem_we[i] = take && lane_req[i].wr_rdn; // RULE3
				s_nxt.rsp[i].rdata_valid = take && !lane_req[i].wr_rdn;
				if (take && !lane_req[i].wr_rdn) begin
					s_nxt.rsp[i].rdata = space_mem[mem_idx[i]]; // RULE5
				end
			end
			// setting applied only while the control is high
			s_nxt.dee_out[i] = s_r.dee_s[i] ?
				s_r.dee[i*CFG_W +: CFG_W] : DEEMP_NONE; // RULE6
			s_nxt.det_out[i] = s_r.oob_s[i] ?
				s_r.oob[i*CFG_W +: CFG_W] : DET_NORMAL; // RULE9
			// power state is set by software and only reported
			s_nxt.pwrst[i] = s_r.pwr[i*PWR_W +: PWR_W]; // RULE8
			// ready needs the lane out of reset, enabled and active
			s_nxt.rdy[i] = s_r.rst_s[i] && s_r.ctrl[i]
				&& (s_r.pwr[i*PWR_W +: PWR_W] == PWR_ACTIVE); // RULE10
			// rising edge of skip moves the word one UI
			fall[i] = s_r.skp_s[i] && !s_r.skp_d[i];
			if (fall[i]) begin
				s_nxt.slip[i] = (s_r.slip[i] == POS_LAST) ?
					POS_ZERO : s_r.slip[i] + 4'h1; // RULE7
			end
		end

		// write address and data, taken in either order
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.awv    = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.wv    = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		// response dropped at the edge that sees bready
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.awv && s_r.wv && !s_r.bvalid) begin
			s_nxt.awv    = 1'b0;
			s_nxt.wv     = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = RESP_OKAY;
			// read-only words accept and ignore writes
			case ({s_r.awaddr[ADDR_W-1:2], 2'b00})
				ADDR_CTRL:  s_nxt.ctrl = merge(s_r.ctrl, s_r.wdata,
					s_r.wstrb, MASK_CTRL);
				ADDR_PWR:   s_nxt.pwr = merge(s_r.pwr, s_r.wdata,
					s_r.wstrb, MASK_PWR);
				ADDR_DEEMP: s_nxt.dee = merge(s_r.dee, s_r.wdata,
					s_r.wstrb, MASK_CFG);
				ADDR_OOB:   s_nxt.oob = merge(s_r.oob, s_r.wdata,
					s_r.wstrb, MASK_CFG);
				ADDR_STAT, ADDR_SLIP: s_nxt.bresp = RESP_OKAY;
				default:    s_nxt.bresp = RESP_SLVERR;
			endcase
		end
		// ready only while idle: one write under way at a time
		s_nxt.awready = !s_nxt.awv && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.wv && !s_nxt.bvalid;

		// read channel, one outstanding
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.arready) begin
			rw = rd_word(s_r, s_axi_araddr);
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rw[31:0];
			s_nxt.rresp  = rw[33:32];
		end
		// no new address until the answer is taken
		s_nxt.arready = !s_nxt.rvalid;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// only aresetn clears state; lane resets act through synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r      <= '0;
			s_r.ctrl <= RST_REG;
			s_r.pwr  <= RST_REG;
			s_r.dee  <= RST_REG;
			s_r.oob  <= RST_REG;
		end else begin
			s_r <= s_nxt;
		end
	end

	// byte store; contents are data, left unreset on purpose
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NL; i++) begin
			// each lane owns its own slice, so lane writes never collide
			if (mem_we[i]) begin
				space_mem[mem_idx[i]] <= lane_req[i].wdata; // RULE4
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from the state register
	// ----------------------------------------------------------------
	// bus write channel
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready  = s_r.wready;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;

	// bus read channel
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;

	// lane ports
	assign lane_rsp      = s_r.rsp;

	// sidebands
	assign tx_deemp      = s_r.dee_out;
	assign rx_det_cfg    = s_r.det_out;
	assign pwr_state     = s_r.pwrst;
	assign phy_ready     = s_r.rdy;
	assign slip_pos      = s_r.slip;

endmodule // lra_lane_port

`default_nettype wire

// ==== verif/lra_lane_asserts.sv ====
// checker: lane 0 handshake, lane reset and sideband relations
// assumes it is bound into lra_lane_port, one clock aclk
`default_nettype none

module lra_lane_asserts (
	input wire logic                                    aclk,
	input wire logic                                    aresetn,
	input wire logic [lra_pkg::NL-1:0]                  lane_resetn,
	input wire lra_pkg::lra_lane_req_t [lra_pkg::NL-1:0] lane_req,
	input wire lra_pkg::lra_lane_rsp_t [lra_pkg::NL-1:0] lane_rsp,
	input wire logic [lra_pkg::NL-1:0]                  deemp_ctl,
	input wire logic [lra_pkg::NL-1:0]                  oob_ctl,
	input wire logic [lra_pkg::NL-1:0][lra_pkg::CFG_W-1:0] tx_deemp,
	input wire logic [lra_pkg::NL-1:0][lra_pkg::CFG_W-1:0] rx_det_cfg,
	input wire logic [lra_pkg::NL-1:0][lra_pkg::PWR_W-1:0] pwr_state,
	input wire logic [lra_pkg::NL-1:0]                  phy_ready,
	input wire logic [lra_pkg::NL-1:0][lra_pkg::POS_W-1:0] slip_pos
);
	import lra_pkg::*;
	// one domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// lane reset is checked three edges deep: it passes a synchroniser
	chk_lane_answer: assert property (
		lane_req[0].request && !lane_rsp[0].ready && lane_resetn[0] &&
		$past(lane_resetn[0], 2) && $past(lane_resetn[0], 3) &&
		$past(aresetn, 3) |=> lane_rsp[0].ready)
		else $error("lane request not answered next cycle");
	chk_ready_pulse: assert property (
		lane_rsp[0].ready |=> !lane_rsp[0].ready)
		else $error("lane ready longer than one cycle");
	chk_read_valid: assert property (
		lane_rsp[0].ready || lane_rsp[0].rdata_valid |-> lane_rsp[0].ready &&
		lane_rsp[0].rdata_valid == !$past(lane_req[0].wr_rdn))
		else $error("read valid does not match direction");
	chk_lane_reset: assert property (
		(!lane_resetn[0]) [*5] |-> lane_rsp[0] == '0)
		else $error("lane answers while held in reset");
	chk_deemp_off: assert property (
		(!deemp_ctl[0]) [*5] |-> tx_deemp[0] == DEEMP_NONE)
		else $error("de-emphasis applied with control low");
	chk_oob_off: assert property (
		(!oob_ctl[0]) [*5] |-> rx_det_cfg[0] == DET_NORMAL)
		else $error("detector setting with oob control low");
	chk_slip_step: assert property (
		$changed(slip_pos[0]) |-> slip_pos[0] == (($past(slip_pos[0]) ==
		POS_LAST) ? POS_ZERO : $past(slip_pos[0]) + 4'h1))
		else $error("slip position moved by other than one");
	chk_ready_power: assert property (
		phy_ready[0] |-> pwr_state[0] == PWR_ACTIVE)
		else $error("phy ready while not in active power");
endmodule // lra_lane_asserts

bind lra_lane_port lra_lane_asserts u_lane_chk (.aclk(aclk),
	.aresetn(aresetn), .lane_resetn(lane_resetn), .lane_req(lane_req),
	.lane_rsp(lane_rsp), .deemp_ctl(deemp_ctl), .oob_ctl(oob_ctl),
	.tx_deemp(tx_deemp), .rx_det_cfg(rx_det_cfg), .pwr_state(pwr_state),
	.phy_ready(phy_ready), .slip_pos(slip_pos));

`default_nettype wire

// ==== verif/lra_fabric_model.sv ====
// fabric model: lane access master, one access at a time, any lane
// assumes the bench pulses go and waits for done
`default_nettype none

module lra_fabric_model (
	input  wire logic                          aclk,
	input  wire logic                          go,
	input  wire logic [1:0]                    lane,
	input  wire logic                          wr,
	input  wire logic [8:0]                    ofs,
	input  wire logic [7:0]                    wd,
	input  wire logic [3:0]                    dly,
	input  wire lra_pkg::lra_lane_rsp_t [3:0]  rsp,
	output var  lra_pkg::lra_lane_req_t [3:0]  req,
	output logic                               done,
	output logic [7:0]                         rd
);
	import lra_pkg::*;
	logic       busy_r;
	logic [1:0] ln_r;
	logic [3:0] wait_r;
	initial begin
		req = '0;
		done = 1'b0;
		rd = '0;
		busy_r = 1'b0;
	end
	// dly makes a slow master; fields never change while requesting
	always @(posedge aclk) begin
		done <= 1'b0;
		if (go && !busy_r) begin
			busy_r <= 1'b1;
			ln_r <= lane;
			wait_r <= dly;
		end else if (busy_r && wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
		end else if (busy_r && !req[ln_r].request) begin
			req[ln_r] <= '{1'b1, wr, ofs, wd};
		end else if (busy_r && rsp[ln_r].ready) begin
			rd <= rsp[ln_r].rdata;
			done <= 1'b1;
			busy_r <= 1'b0;
			// released fields show junk, not the last value
			req[ln_r] <= '{1'b0, !wr, ~ofs, ~wd};
		end
	end
endmodule // lra_fabric_model

`default_nettype wire

// ==== verif/lra_lane_port_tb_top.sv ====
// bench: register bank over the bus, lane ports through the fabric model
// assumes lra_lane_port with the checker bound in
`default_nettype none

module lra_lane_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import lra_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic arvalid = 1'b0, bready = 1'b1, rready = 1'b1, go = 1'b0, wr = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, done;
	logic [7:0] awaddr = '0, araddr = '0, wd = '0, rd, r, l;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF, dly = '0, phy_ready;
	logic [3:0] lane_resetn = 4'hF, oob_ctl = '0, deemp_ctl = '0;
	logic [3:0] skip_bit = '0;
	logic [1:0] bresp, rresp, lane = '0;
	logic [8:0] ofs = '0;
	lra_lane_req_t [NL-1:0] lane_req;
	lra_lane_rsp_t [NL-1:0] lane_rsp;
	logic [NL-1:0][CFG_W-1:0] tx_deemp, rx_det_cfg;
	logic [NL-1:0][PWR_W-1:0] pwr_state;
	logic [NL-1:0][POS_W-1:0] slip_pos;
	logic [7:0]  ra [4] = '{ADDR_CTRL, ADDR_PWR, ADDR_DEEMP, ADDR_OOB};
	logic [31:0] rm [4] = '{MASK_CTRL, MASK_PWR, MASK_CFG, MASK_CFG};
	int fail_count = 0, checks_done = 0;
	always #5 aclk = ~aclk;

	lra_lane_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.lane_resetn(lane_resetn), .lane_req(lane_req), .lane_rsp(lane_rsp),
		.oob_ctl(oob_ctl), .deemp_ctl(deemp_ctl), .skip_bit(skip_bit),
		.tx_deemp(tx_deemp), .rx_det_cfg(rx_det_cfg), .pwr_state(pwr_state),
		.phy_ready(phy_ready), .slip_pos(slip_pos));
	lra_fabric_model u_fab (.aclk(aclk), .go(go), .lane(lane), .wr(wr),
		.ofs(ofs), .wd(wd), .dly(dly), .rsp(lane_rsp), .req(lane_req),
		.done(done), .rd(rd));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tmo(input logic ok);
		if (!ok) begin
			fail_count++;
			$display("CHECK FAILED wait exp 1 got 0");
			finish_test;
		end
	endtask
	// bready and rready stay high, so every answer is taken at once
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit ad = 0, dd = 0, bd = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (int i = 0; i < 50 && !bd; i++) begin
			@(posedge aclk);
			if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
			if (wready && !dd) begin dd = 1; wvalid <= 1'b0; end
			if (bvalid) begin bd = 1; chk("bresp", er, bresp); end
		end
		tmo(bd);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		bit ad = 0, rd_done = 0;
		araddr <= a;
		arvalid <= 1'b1;
		for (int i = 0; i < 50 && !rd_done; i++) begin
			@(posedge aclk);
			if (arready && !ad) begin ad = 1; arvalid <= 1'b0; end
			if (rvalid) begin
				rd_done = 1;
				chk("rdata", e, rdata);
				chk("rresp", er, rresp);
			end
		end
		tmo(rd_done);
	endtask
	task automatic lane_go(input logic [1:0] ln, input logic w,
		input logic [8:0] o, input logic [7:0] d, input logic [3:0] dl);
		lane <= ln;
		wr <= w;
		ofs <= o;
		wd <= d;
		dly <= dl;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
	endtask
	task automatic lane_fin(output logic [7:0] rv);
		int i;
		for (i = 0; i < 60 && !done; i++) @(posedge aclk);
		tmo(done);
		rv = rd;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			axi_rd(ra[i], RST_REG, RESP_OKAY);
			axi_wr(ra[i], 32'hFFFFFFFF, RESP_OKAY);
			axi_rd(ra[i], rm[i], RESP_OKAY);
			axi_wr(ra[i], 32'h0, RESP_OKAY);
		end
		axi_wr(8'h18, 32'h1, RESP_SLVERR);
		axi_rd(8'h18, 32'h0, RESP_SLVERR);
		axi_wr(ADDR_SLIP, 32'hFFFF, RESP_OKAY);
		axi_rd(ADDR_SLIP, 32'h0, RESP_OKAY);
		$display("test registers done");
		// same low offset in both spaces must hold different bytes
		for (l = 0; l < 4; l++) begin
			lane_go(l[1:0], 1'b1, 9'h003, 8'hA0 + l, l[3:0]); lane_fin(r);
			lane_go(l[1:0], 1'b1, 9'h103, 8'h50 + l, 4'h0); lane_fin(r);
		end
		for (l = 0; l < 4; l++) begin
			lane_go(l[1:0], 1'b0, 9'h003, 8'h0, 4'h0); lane_fin(r);
			chk("pma_byte", 8'hA0 + l, r);
			lane_go(l[1:0], 1'b0, 9'h103, 8'h0, 4'h0); lane_fin(r);
			chk("pcs_byte", 8'h50 + l, r);
		end
		$display("test lane access done");
		// lane 0, so the bound checker sees the reset too
		lane_resetn[0] <= 1'b0;
		repeat (4) @(posedge aclk);
		lane_go(2'd0, 1'b1, 9'h005, 8'h3C, 4'h0);
		repeat (8) begin
			@(posedge aclk);
			chk("lane_rsp_rst", 32'h0, lane_rsp[0]);
		end
		lane_resetn[0] <= 1'b1;
		lane_fin(r);
		lane_go(2'd0, 1'b0, 9'h005, 8'h0, 4'h0); lane_fin(r);
		chk("after_rst", 8'h3C, r);
		$display("test lane reset done");
		axi_wr(ADDR_DEEMP, 32'h4321, RESP_OKAY);
		axi_wr(ADDR_OOB, 32'h8765, RESP_OKAY);
		axi_wr(ADDR_CTRL, 32'hF, RESP_OKAY);
		axi_wr(ADDR_PWR, 32'h10, RESP_OKAY);
		repeat (5) @(posedge aclk);
		chk("deemp_off", 32'h0, tx_deemp);
		chk("pwr_lane2", 32'h1, pwr_state[2]);
		chk("phy_ready", 32'hB, phy_ready);
		deemp_ctl <= 4'hF;
		oob_ctl <= 4'hF;
		repeat (5) @(posedge aclk);
		chk("deemp_on", 32'h4321, tx_deemp);
		chk("oob_on", 32'h8765, rx_det_cfg);
		axi_wr(ADDR_STAT, 32'hFFFFFFFF, RESP_OKAY);
		axi_rd(ADDR_STAT, 32'h0F0F0F0B, RESP_OKAY);
		$display("test sideband done");
		// eleven rising edges wrap a ten-place position round to one
		repeat (11) begin
			skip_bit[0] <= 1'b1;
			repeat (4) @(posedge aclk);
			skip_bit[0] <= 1'b0;
			repeat (4) @(posedge aclk);
		end
		chk("slip_pos", 32'h1, slip_pos[0]);
		axi_rd(ADDR_SLIP, 32'h1, RESP_OKAY);
		$display("test bit skip done");
		finish_test;
	end
endmodule // lra_lane_port_tb_top

`default_nettype wire
